//--- rtl/dscp_pkg.sv
package dscp_pkg;

  // ----------------------------------------------------------------
  // register map of the serial port
  // ----------------------------------------------------------------
  localparam logic [4:0] ADDR_MODE = 5'h00; // mode register, index 0
  localparam int NUM_REGS = 4;              // registers implemented
  localparam int POS_BIDIR = 7;             // data pin direction bit
  localparam int POS_LSB_FIRST = 6;         // bit order bit
  localparam int POS_SOFT_RESET = 5;        // software reset bit
  localparam logic [7:0] RST_MODE = 8'h00;  // mode register default
  localparam logic [7:0] RST_OTHER = 8'h00; // other registers default

  // ----------------------------------------------------------------
  // frame layout
  // ----------------------------------------------------------------
  localparam int POS_READ = 7;              // instruction read flag
  localparam logic [2:0] BIT_LAST = 3'h7;   // last bit of a byte

  // ----------------------------------------------------------------
  // rate clock divider for the alternate output function
  // ----------------------------------------------------------------
  localparam logic [3:0] RATE_DIV_LAST = 4'h7; // toggle every 8 cycles

  typedef enum logic [1:0] {
    DSCP_IDLE,
    DSCP_INSTR,
    DSCP_DATA
  } dscp_state_t;

endpackage : dscp_pkg

//--- rtl/dscp_serial_port.sv
// Functional notes
// - mode bit 7 sets data pin direction
// - separate output drives reads unless bidirectional
// - sample incoming bits on rising serial clock
// - launch outgoing bits on falling serial clock
// - select high resets frame engine, restarts instruction
// - hardware reset pin restores every register
// - writing mode bit 5 soft-resets registers
// - soft reset leaves mode register untouched
// - separate output may carry data rate clock
`timescale 1ns/1ns
`default_nettype none

module dscp_serial_port
  import dscp_pkg::*;
(
  input wire logic ref_clk,           // block clock, 100 MHz
  input wire logic reset_n,           // async reset, active low
  input wire logic hwResetPin,        // hardware reset pin, active high
  input wire logic port_select_n,     // chip select, active low
  input wire logic serialClk,         // serial clock from the host
  input wire logic serialDataIn,      // data pin, input side
  output logic serialDataOut,         // data pin, output side
  output logic serialDataOe_n,        // data pin enable, low drives
  output logic separate_data_out,     // separate output value
  output logic separateDataOe_n,      // separate output enable, low drives
  input wire logic rateClkSelect,     // 1: separate output shows rate clk
  output logic [7:0] modeReg,         // mode register contents
  output logic [7:0] cfgReg1,         // register 1 contents
  output logic [7:0] cfgReg2          // register 2 contents
);

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [1:0] csSync_ff, nxt_csSync;   // chip select stages
  logic [1:0] sckSync_ff, nxt_sckSync; // serial clock stages
  logic [1:0] sdiSync_ff, nxt_sdiSync; // data in stages
  logic [1:0] hrSync_ff, nxt_hrSync;   // hardware reset stages
  logic sckPrev_ff, nxt_sckPrev;       // last synced serial clock

  // shift the pins through two stages; only stage 1 is read by logic
  always_comb begin
    nxt_csSync = {csSync_ff[0], port_select_n};
    nxt_sckSync = {sckSync_ff[0], serialClk};
    nxt_sdiSync = {sdiSync_ff[0], serialDataIn};
    nxt_hrSync = {hrSync_ff[0], hwResetPin};
    nxt_sckPrev = sckSync_ff[1];
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      csSync_ff <= 2'h3;
      sckSync_ff <= 2'h0;
      sdiSync_ff <= 2'h0;
      hrSync_ff <= 2'h0;
      sckPrev_ff <= 1'b0;
    end else begin
      csSync_ff <= nxt_csSync;
      sckSync_ff <= nxt_sckSync;
      sdiSync_ff <= nxt_sdiSync;
      hrSync_ff <= nxt_hrSync;
      sckPrev_ff <= nxt_sckPrev;
    end
  end

  logic csHigh;   // select deasserted
  logic sckRise;  // rising serial clock seen
  logic sckFall;  // falling serial clock seen
  logic sdiBit;   // synced data bit
  logic hwReset;  // synced hardware reset
  assign csHigh = csSync_ff[1];
  assign sckRise = sckSync_ff[1] & ~sckPrev_ff;
  assign sckFall = ~sckSync_ff[1] & sckPrev_ff;
  assign sdiBit = sdiSync_ff[1];
  assign hwReset = hrSync_ff[1];

  // ----------------------------------------------------------------
  // frame engine and register file
  // ----------------------------------------------------------------
  dscp_state_t state_ff, nxt_state;        // frame phase
  logic [2:0] bitCnt_ff, nxt_bitCnt;       // bit within byte
  logic [7:0] shiftIn_ff, nxt_shiftIn;     // receive shifter
  logic [7:0] shiftOut_ff, nxt_shiftOut;   // transmit shifter
  logic isRead_ff, nxt_isRead;             // current frame reads
  logic [4:0] addr_ff, nxt_addr;           // current register address
  logic outBit_ff, nxt_outBit;             // launched read bit
  logic [7:0] regs_ff [NUM_REGS];          // register storage
  logic [7:0] nxtRegs [NUM_REGS];          // next register values
  logic [7:0] rxByte;                      // completed byte
  logic lsbFirst;                          // bit order from mode reg
  logic [1:0] regIdx;                      // register index

  assign lsbFirst = regs_ff[0][POS_LSB_FIRST];
  assign regIdx = addr_ff[1:0];

  always_comb begin
    nxt_state = state_ff;
    nxt_bitCnt = bitCnt_ff;
    nxt_shiftIn = shiftIn_ff;
    nxt_shiftOut = shiftOut_ff;
    nxt_isRead = isRead_ff;
    nxt_addr = addr_ff;
    nxt_outBit = outBit_ff;
    for (int i = 0; i < NUM_REGS; i++) begin
      nxtRegs[i] = regs_ff[i];
    end
    rxByte = lsbFirst ? {sdiBit, shiftIn_ff[7:1]} : {shiftIn_ff[6:0], sdiBit};
    if (csHigh) begin
      // select high puts the engine back at an instruction byte
      nxt_state = DSCP_IDLE;
      nxt_bitCnt = 3'h0;
    end else begin
      if (state_ff == DSCP_IDLE) begin
        nxt_state = DSCP_INSTR;
      end
      if (sckRise) begin
        nxt_shiftIn = rxByte;
        nxt_bitCnt = bitCnt_ff + 3'h1;
        if (bitCnt_ff == BIT_LAST) begin
          if (state_ff != DSCP_DATA) begin
            // instruction: read flag then address
            nxt_isRead = rxByte[POS_READ];
            nxt_addr = rxByte[4:0];
            nxt_state = DSCP_DATA;
            nxt_shiftOut = (rxByte[4:0] < 5'(NUM_REGS))
                           ? regs_ff[rxByte[1:0]] : 8'h00;
          end else begin
            if (!isRead_ff) begin
              if (addr_ff == ADDR_MODE && rxByte[POS_SOFT_RESET]) begin
                // soft reset spares the mode register
                for (int i = 1; i < NUM_REGS; i++) begin
                  nxtRegs[i] = RST_OTHER;
                end
              end else if (addr_ff < 5'(NUM_REGS)) begin
                nxtRegs[regIdx] = rxByte;
              end
            end
            // streaming: move to the next register
            nxt_addr = addr_ff + 5'h1;
            nxt_shiftOut = (addr_ff + 5'h1 < 5'(NUM_REGS))
                           ? regs_ff[2'(addr_ff + 5'h1)] : 8'h00;
          end
        end
      end
      if (sckFall && state_ff == DSCP_DATA && isRead_ff) begin
        // launch on the falling edge, host samples on the next rise
        nxt_outBit = lsbFirst ? shiftOut_ff[0] : shiftOut_ff[7];
        nxt_shiftOut = lsbFirst ? {1'b0, shiftOut_ff[7:1]}
                                : {shiftOut_ff[6:0], 1'b0};
      end
    end
    if (hwReset) begin
      // pin reset beats everything, mode register included
      nxt_state = DSCP_IDLE;
      nxt_bitCnt = 3'h0;
      nxtRegs[0] = RST_MODE;
      for (int i = 1; i < NUM_REGS; i++) begin
        nxtRegs[i] = RST_OTHER;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff <= DSCP_IDLE;
      bitCnt_ff <= 3'h0;
      shiftIn_ff <= 8'h00;
      shiftOut_ff <= 8'h00;
      isRead_ff <= 1'b0;
      addr_ff <= 5'h00;
      outBit_ff <= 1'b0;
      regs_ff[0] <= RST_MODE;
      for (int i = 1; i < NUM_REGS; i++) begin
        regs_ff[i] <= RST_OTHER;
      end
    end else begin
      state_ff <= nxt_state;
      bitCnt_ff <= nxt_bitCnt;
      shiftIn_ff <= nxt_shiftIn;
      shiftOut_ff <= nxt_shiftOut;
      isRead_ff <= nxt_isRead;
      addr_ff <= nxt_addr;
      outBit_ff <= nxt_outBit;
      for (int i = 0; i < NUM_REGS; i++) begin
        regs_ff[i] <= nxtRegs[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // data rate clock for the alternate output use
  // ----------------------------------------------------------------
  logic [3:0] rateCnt_ff, nxt_rateCnt; // divider count
  logic rateClk_ff, nxt_rateClk;       // divided clock level

  always_comb begin
    nxt_rateCnt = rateCnt_ff + 4'h1;
    nxt_rateClk = rateClk_ff;
    if (rateCnt_ff == RATE_DIV_LAST) begin
      nxt_rateCnt = 4'h0;
      nxt_rateClk = ~rateClk_ff;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rateCnt_ff <= 4'h0;
      rateClk_ff <= 1'b0;
    end else begin
      rateCnt_ff <= nxt_rateCnt;
      rateClk_ff <= nxt_rateClk;
    end
  end

  // ----------------------------------------------------------------
  // pin drivers
  // ----------------------------------------------------------------
  logic bidir;       // data pin acts as input and output
  logic readActive;  // read data phase while selected
  assign bidir = regs_ff[0][POS_BIDIR];
  assign readActive = (state_ff == DSCP_DATA) & isRead_ff & ~csHigh;

  assign modeReg = regs_ff[0];
  assign cfgReg1 = regs_ff[1];
  assign cfgReg2 = regs_ff[2];
  assign serialDataOut = outBit_ff;
  // data pin drives only when bidirectional and a read is under way
  assign serialDataOe_n = ~(bidir & readActive);
  // separate output floats once the data pin is bidirectional, unless rateClkSelect puts the rate clock on it
  assign separate_data_out = rateClkSelect ? rateClk_ff : outBit_ff;
  assign separateDataOe_n = rateClkSelect ? 1'b0
                          : ~(~bidir & readActive);

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_sdo_float: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    (bidir && !rateClkSelect) |-> separateDataOe_n)
    else $error("separate output driven in bidirectional mode");
  chk_pin_dir: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    !bidir |-> serialDataOe_n)
    else $error("data pin driven while configured as input");
  chk_cs_resync: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    csHigh |=> (state_ff == DSCP_IDLE && bitCnt_ff == 3'h0))
    else $error("select high did not restart the frame");
  chk_hw_reset: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    hwReset |=> (regs_ff[0] == RST_MODE && regs_ff[1] == RST_OTHER))
    else $error("hardware reset left a register dirty");
  chk_soft_keep: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    (!hwReset && !(sckRise && !csHigh && addr_ff == ADDR_MODE))
    |=> regs_ff[0] == $past(regs_ff[0]))
    else $error("mode register changed without a write");
  chk_rise_only: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    (!sckRise && !hwReset) |=> $stable(shiftIn_ff))
    else $error("input shifted without rising serial clock");
  chk_fall_only: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    !sckFall |=> $stable(outBit_ff))
    else $error("output bit moved without falling serial clock");
  chk_rate_out: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    rateClkSelect |-> (separate_data_out == rateClk_ff && !separateDataOe_n))
    else $error("rate clock not on separate output");

endmodule : dscp_serial_port

`default_nettype wire

//--- verif/dscp_host_model.sv
`timescale 1ns/1ns
`default_nettype none

module dscp_host_model (
  output logic port_select_n, // chip select, active low
  output logic serialClk, // serial clock, still outside frames
  output logic hostBit, // value the host puts on the data pin
  output logic hostOe, // host drives the data pin
  input wire logic sdioWire, // resolved data pin level
  input wire logic separate_data_out, // separate output pin
  input wire logic separateDataOe_n // separate output enable
);
  logic lastSepOe; // separate enable seen at the last rising edge
  logic lsbMode; // 1: bytes go out lsb first, set by the bench

  initial begin
    port_select_n = 1'b1;
    serialClk = 1'b0;
    hostBit = 1'b0;
    hostOe = 1'b1;
    lastSepOe = 1'b1;
    lsbMode = 1'b0;
  end

  // ----------------------------------------------------------------
  // one 125 ns serial clock period, data moved while clock is low
  // ----------------------------------------------------------------
  task automatic bitCycle(input logic dOut, input logic useSdio,
                          output logic dIn);
    begin
      hostBit = dOut;
      #62 serialClk = 1'b1;
      dIn = useSdio ? sdioWire : separate_data_out;
      lastSepOe = separateDataOe_n;
      #63 serialClk = 1'b0;
    end
  endtask

  // instruction byte then one data byte, msb first unless lsbMode
  task automatic xfer(input logic rd, input logic [4:0] addr,
                      input logic [7:0] wData, input logic bidir,
                      output logic [7:0] rData);
    logic [7:0] instr;
    logic b;
    begin
      instr = {rd, 2'b00, addr};
      port_select_n = 1'b0;
      #40;
      for (int i = 7; i >= 0; i--) begin
        bitCycle(lsbMode ? instr[7 - i] : instr[i], bidir, b);
      end
      hostOe = !rd; // let go of the pin for the answer
      for (int i = 7; i >= 0; i--) begin
        bitCycle(lsbMode ? wData[7 - i] : wData[i], bidir, b);
        rData[lsbMode ? 7 - i : i] = b;
      end
      #40 port_select_n = 1'b1;
      hostOe = 1'b1;
      #60;
    end
  endtask

  // a frame cut short, then a brief high pulse on select
  task automatic abortFrame(input int nBits);
    logic b;
    begin
      port_select_n = 1'b0;
      #40;
      repeat (nBits) bitCycle(1'b1, 1'b0, b);
      port_select_n = 1'b1;
      #40;
    end
  endtask
endmodule // dscp_host_model

`default_nettype wire

//--- verif/dac_serial_control_port_tb.sv
`timescale 1ns/1ns
`default_nettype none

module dac_serial_control_port_tb;
  import dscp_pkg::*;
  typedef struct packed {
    logic rd;
    logic [4:0] addr;
    logic [7:0] data;
    logic [7:0] exp;
  } dscp_row_t;
  logic ref_clk, reset_n, hwResetPin, rateClkSelect, port_select_n;
  logic serialClk, hostBit, hostOe, sdioWire, serialDataOut;
  logic serialDataOe_n, separate_data_out, separateDataOe_n;
  logic [7:0] modeReg, cfgReg1, cfgReg2, rdV, nToggles;
  int n_errors = 0;
  int num_checks = 0;
  // back-to-back frames; address 6 must not alias onto register 2
  dscp_row_t rows [0:7] = '{'{1'b0, 5'h01, 8'hA5, 8'hA5},
    '{1'b0, 5'h02, 8'h3C, 8'h3C}, '{1'b0, 5'h03, 8'h5A, 8'h00},
    '{1'b0, 5'h06, 8'hFF, 8'h00}, '{1'b1, 5'h01, 8'h00, 8'hA5},
    '{1'b1, 5'h02, 8'h00, 8'h3C}, '{1'b1, 5'h03, 8'h00, 8'h5A},
    '{1'b1, 5'h06, 8'h00, 8'h00}};

  // the data pin: whoever is enabled wins, released pin flips
  assign sdioWire = !serialDataOe_n ? serialDataOut :
                    (hostOe ? hostBit : !hostBit);

  dscp_serial_port i_dscp_serial_port (.ref_clk(ref_clk),
    .reset_n(reset_n), .hwResetPin(hwResetPin),
    .port_select_n(port_select_n), .serialClk(serialClk),
    .serialDataIn(sdioWire), .serialDataOut(serialDataOut),
    .serialDataOe_n(serialDataOe_n),
    .separate_data_out(separate_data_out),
    .separateDataOe_n(separateDataOe_n), .rateClkSelect(rateClkSelect),
    .modeReg(modeReg), .cfgReg1(cfgReg1), .cfgReg2(cfgReg2));

  dscp_host_model i_dscp_host_model (.port_select_n(port_select_n),
    .serialClk(serialClk), .hostBit(hostBit), .hostOe(hostOe),
    .sdioWire(sdioWire), .separate_data_out(separate_data_out),
    .separateDataOe_n(separateDataOe_n));

  // ----------------------------------------------------------------
  // compare tasks and the closing report
  // ----------------------------------------------------------------
  task automatic check8(input string what, input logic [7:0] e,
                        input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic check1(input string what, input logic e, input logic g);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %b seen %b", what, e, g);
    end
  endtask

  task automatic final_report();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // watchdog: a hang counts as a mismatch
  initial begin
    #500000;
    n_errors++;
    final_report();
  end

  initial begin
    reset_n = 1'b0;
    hwResetPin = 1'b0;
    rateClkSelect = 1'b0;
    repeat (2) @(posedge ref_clk);
    #1 reset_n = 1'b1;
    repeat (5) @(posedge ref_clk);
    check8("mode after reset", 8'h00, modeReg);
    check8("reg1 after reset", 8'h00, cfgReg1);
    check1("pin enable idle", 1'b1, serialDataOe_n);
    foreach (rows[i]) begin
      i_dscp_host_model.xfer(rows[i].rd, rows[i].addr, rows[i].data,
                             1'b0, rdV);
      if (rows[i].rd) begin
        check8("read data", rows[i].exp, rdV);
        check1("sdo enable", 1'b0, i_dscp_host_model.lastSepOe);
      end else if (rows[i].addr == 5'h01) begin
        check8("reg1", rows[i].exp, cfgReg1);
      end else if (rows[i].addr == 5'h02) begin
        check8("reg2", rows[i].exp, cfgReg2);
      end
    end
    // a broken frame must not shift the next one
    i_dscp_host_model.abortFrame(5);
    i_dscp_host_model.xfer(1'b0, 5'h01, 8'h96, 1'b0, rdV);
    check8("reg1 after abort", 8'h96, cfgReg1);
    // turn the data pin round and read through it
    i_dscp_host_model.xfer(1'b0, ADDR_MODE, 8'h80, 1'b0, rdV);
    check8("mode bidir", 8'h80, modeReg);
    i_dscp_host_model.xfer(1'b1, 5'h01, 8'h00, 1'b1, rdV);
    check8("bidir read", 8'h96, rdV);
    check1("sdo high-z", 1'b1, i_dscp_host_model.lastSepOe);
    // software reset keeps the mode register as it was
    i_dscp_host_model.xfer(1'b0, ADDR_MODE, 8'hA0, 1'b0, rdV);
    check8("mode kept", 8'h80, modeReg);
    check8("reg1 cleared", 8'h00, cfgReg1);
    check8("reg2 cleared", 8'h00, cfgReg2);
    @(posedge ref_clk);
    #1 hwResetPin = 1'b1;
    repeat (5) @(posedge ref_clk);
    #1 hwResetPin = 1'b0;
    repeat (5) @(posedge ref_clk);
    check8("mode after pin", 8'h00, modeReg);
    // bit order flipped: instruction and data travel lsb first
    i_dscp_host_model.xfer(1'b0, ADDR_MODE, 8'h40, 1'b0, rdV);
    check8("mode lsb", 8'h40, modeReg);
    i_dscp_host_model.lsbMode = 1'b1;
    i_dscp_host_model.xfer(1'b0, 5'h01, 8'h3A, 1'b0, rdV);
    check8("reg1 lsb first", 8'h3A, cfgReg1);
    i_dscp_host_model.xfer(1'b1, 5'h01, 8'h00, 1'b0, rdV);
    check8("lsb read", 8'h3A, rdV);
    #1 rateClkSelect = 1'b1;
    repeat (4) @(posedge ref_clk);
    check1("rate enable", 1'b0, separateDataOe_n);
    nToggles = 8'h00;
    repeat (64) begin
      rdV[0] = separate_data_out;
      @(posedge ref_clk);
      #1 nToggles = nToggles + {7'h00, separate_data_out ^ rdV[0]};
    end
    check8("rate toggles", 8'h08, nToggles);
    final_report();
  end
endmodule // dac_serial_control_port_tb

`default_nettype wire
